// ---- bench/dac_loader_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
module dac_loader_asserts
  import dac_loader_pkg::*;
(
  // watched ports
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic serial_clk,
  input wire logic frame_n,
  input wire logic serial_in,
  input wire logic serial_out_o,
  input wire logic serial_out_oe,
  input wire logic load_strobe_n,
  input wire logic clear_output_n,
  input wire logic [SEG_COUNT-1:0] segment_switches,
  input wire logic [LADDER_BITS-1:0] ladder_switches,
  input wire logic [WORD_BITS-1:0] input_code,
  input wire logic [WORD_BITS-1:0] dac_code,
  input wire logic output_cleared
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_load_run;
    (!load_strobe_n && frame_n) [*5];
  endsequence
  sequence s_frame_run;
    !frame_n [*5];
  endsequence
  chk_load_copy: assert property (s_load_run |-> dac_code == input_code)
    else $error("dac code not loaded");
  chk_load_idle: assert property (load_strobe_n [*4] |-> $stable(dac_code))
    else $error("dac code moved without load");
  chk_frame_quiet: assert property (s_frame_run |-> $stable(input_code))
    else $error("input code moved inside frame");
  chk_seg_thermo: assert property (!output_cleared |=>
    segment_switches == 15'((16'h1 << $past(dac_code[15:12])) - 16'h1))
    else $error("segment switches wrong");
  chk_ladder_bits: assert property (!output_cleared |=>
    ladder_switches == $past(dac_code[11:0]))
    else $error("ladder switches wrong");
  chk_clear_set: assert property (!clear_output_n [*4] |-> output_cleared)
    else $error("clear not applied");
  chk_clear_mid: assert property (output_cleared |=>
    segment_switches == 15'h00FF && ladder_switches == 12'h000)
    else $error("cleared switches wrong");
  chk_oe_idle: assert property (frame_n [*2] |-> !serial_out_oe)
    else $error("serial out driven outside frame");
endmodule : dac_loader_asserts
bind serial_dac_input_loader dac_loader_asserts chk_u (.*);
`default_nettype wire

// ---- bench/host_link.sv ----
`timescale 1ns/1ns
`default_nettype none
module host_link (
  // link to device
  output logic sclk,
  output logic frame_n,
  output logic sdi,
  input wire logic oe
);
  logic [15:0] rb;
  initial begin
    sclk = 1;
    frame_n = 1;
    sdi = 0;
    rb = 16'h0000;
  end
  task automatic send(input logic [31:0] w, input int n);
    #3 rb = 16'h0000;
    frame_n = 0;
    #48;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = w[i];
      #24 sclk = 0;
      #24 sclk = 1;
      rb = {rb[14:0], ~oe};
    end
    #24 sdi = ~sdi;
    frame_n = 1;
    #72;
  endtask : send
  // clock and data toggle with frame high
  task automatic idle_clocks(input int n);
    for (int i = 0; i < n; i++) begin
      #24 sdi = ~sdi;
      sclk = 0;
      #24 sclk = 1;
    end
  endtask : idle_clocks
endmodule : host_link
`default_nettype wire

// ---- bench/tb_serial_dac_input_loader.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_serial_dac_input_loader
  import dac_loader_pkg::*;
;
  logic clk_sys, resetn, sclk, frame_n, sdi, load_strobe_n, clear_output_n;
  logic so_o, oe, cleared;
  logic [14:0] seg;
  logic [11:0] lad;
  logic [15:0] in_c, dac_c, prev;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  typedef struct packed {logic [15:0] w; logic [14:0] s;} row_t;
  row_t rows [4] = '{'{16'h0000, 15'h0000}, '{16'hFFFF, 15'h7FFF},
    '{16'h8001, 15'h00FF}, '{16'h3ABC, 15'h0007}};
  serial_dac_input_loader dut_u (.clk_sys(clk_sys), .resetn(resetn),
    .serial_clk(sclk), .frame_n(frame_n), .serial_in(sdi),
    .serial_out_o(so_o), .serial_out_oe(oe), .load_strobe_n(load_strobe_n),
    .clear_output_n(clear_output_n), .segment_switches(seg),
    .ladder_switches(lad), .input_code(in_c), .dac_code(dac_c),
    .output_cleared(cleared));
  host_link host_u (.sclk(sclk), .frame_n(frame_n), .sdi(sdi), .oe(oe));
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : wt
  task automatic ld;
    load_strobe_n = 0;
    wt(6);
    load_strobe_n = 1;
    wt(6);
  endtask : ld
  task automatic stop_test;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test;
    end
  end
  initial begin
    resetn = 0;
    load_strobe_n = 1;
    clear_output_n = 1;
    wt(20);
    resetn = 1;
    wt(4);
    chk("input", in_c, 16'h8000);
    chk("dac", dac_c, 16'h8000);
    chk("segment", {1'b0, seg}, 16'h00FF);
    chk("ladder", {4'h0, lad}, 16'h0000);
    chk("open drain", {15'h0000, so_o}, 16'h0000);
    $display("reset test done");
    foreach (rows[i]) begin
      prev = dac_c;
      host_u.send({16'h0000, rows[i].w}, 16);
      wt(8);
      chk("input", in_c, rows[i].w);
      chk("readback", host_u.rb, prev);
      chk("held dac", dac_c, prev);
      ld;
      chk("dac", dac_c, rows[i].w);
      chk("segment", {1'b0, seg}, {1'b0, rows[i].s});
      chk("ladder", {4'h0, lad}, {4'h0, rows[i].w[11:0]});
      $display("row %0d done", i);
    end
    host_u.send(32'h0000_0155, 10);
    wt(8);
    chk("short frame", in_c, 16'h3ABC);
    host_u.send(32'h000A_BCDE, 20);
    wt(8);
    chk("long frame", in_c, 16'hBCDE);
    chk("chain out", host_u.rb, 16'hABCA);
    $display("frame length test done");
    load_strobe_n = 0;
    host_u.send(32'h0000_1234, 16);
    wt(8);
    chk("sync load", dac_c, 16'h1234);
    load_strobe_n = 1;
    clear_output_n = 0;
    wt(6);
    chk("cleared", {15'h0000, cleared}, 16'h0001);
    chk("clear ladder", {4'h0, lad}, 16'h0000);
    chk("clear segment", {1'b0, seg}, 16'h00FF);
    chk("clear dac", dac_c, 16'h1234);
    clear_output_n = 1;
    wt(6);
    chk("clear kept", {15'h0000, cleared}, 16'h0001);
    ld;
    chk("uncleared", {15'h0000, cleared}, 16'h0000);
    chk("ladder back", {4'h0, lad}, 16'h0234);
    $display("clear test done");
    host_u.idle_clocks(8);
    host_u.send(32'h0000_0000, 0);
    wt(8);
    chk("idle clocks", in_c, 16'h1234);
    chk("idle dac", dac_c, 16'h1234);
    $display("idle clock test done");
    resetn = 0;
    wt(2);
    chk("reset input", in_c, 16'h8000);
    chk("reset dac", dac_c, 16'h8000);
    chk("reset cleared", {15'h0000, cleared}, 16'h0000);
    resetn = 1;
    wt(4);
    chk("reset segment", {1'b0, seg}, 16'h00FF);
    chk("reset ladder", {4'h0, lad}, 16'h0000);
    $display("mid-run reset test done");
    stop_test;
  end
endmodule : tb_serial_dac_input_loader
`default_nettype wire

// ---- hdl/dac_loader_pkg.sv ----
package dac_loader_pkg;

  // word and field sizes
  localparam int WORD_BITS = 16;
  localparam int SEG_BITS = 4;
  localparam int SEG_COUNT = 15;
  localparam int LADDER_BITS = 12;
  localparam int CNT_BITS = 5;

  // positions
  localparam int WORD_MSB = 15;
  localparam int SEG_LSB = 12;
  localparam int LADDER_MSB = 11;

  // values after reset, and bit counter step and limit
  localparam logic [15:0] MIDSCALE_CODE = 16'h8000;
  localparam logic [4:0] BITS_PER_WORD = 5'h10;
  localparam logic [4:0] CNT_FIRST = 5'h01;
  localparam logic [4:0] CNT_RESET = 5'h00;
  localparam logic [2:0] SYNC_RESET_HIGH = 3'h7;
  localparam logic [14:0] SEG_RESET = 15'h00FF;
  localparam logic [11:0] LADDER_RESET = 12'h000;

  // rates
  localparam int SYS_CLK_HZ = 100_000_000;
  localparam int LINK_MAX_HZ = 10_000_000;
  localparam int SYS_PER_LINK_BIT = SYS_CLK_HZ / LINK_MAX_HZ;

endpackage : dac_loader_pkg

// ---- hdl/segment_decoder.sv ----
`timescale 1ns/1ns
`default_nettype none

module segment_decoder
  import dac_loader_pkg::*;
(
  // top bits of the code
  input wire logic [SEG_BITS-1:0] code_top,
  // thermometer switches, bit i is switch i+1
  output logic [SEG_COUNT-1:0] thermo
);

  genvar i;

  generate
    for (i = 0; i < SEG_COUNT; i = i + 1) begin : g_seg
      assign thermo[i] = (code_top > SEG_BITS'(i));
    end
  endgenerate

endmodule : segment_decoder

`default_nettype wire

// ---- hdl/serial_dac_input_loader.sv ----
`timescale 1ns/1ns
`default_nettype none

module serial_dac_input_loader
  import dac_loader_pkg::*;
(
  // system clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // serial link from host
  input wire logic serial_clk,
  input wire logic frame_n,
  input wire logic serial_in,
  // open-drain serial output
  output logic serial_out_o,
  output logic serial_out_oe,
  // control pins
  input wire logic load_strobe_n,
  input wire logic clear_output_n,
  // converter switch drive
  output logic [SEG_COUNT-1:0] segment_switches,
  output logic [LADDER_BITS-1:0] ladder_switches,
  // register view
  output logic [WORD_BITS-1:0] input_code,
  output logic [WORD_BITS-1:0] dac_code,
  output logic output_cleared
);

  // link domain state
  logic [WORD_BITS-1:0] shift_reg;
  logic [WORD_BITS-1:0] readback_reg;
  logic [CNT_BITS-1:0] bit_cnt_reg;
  logic [CNT_BITS-1:0] bit_cnt_next;
  logic fresh_reg;
  logic sdo_low_reg;
  logic sdo_low_next;
  wire logic frame_idle;
  wire logic word_full;

  // system domain state
  logic [WORD_BITS-1:0] input_reg;
  logic [WORD_BITS-1:0] input_next;
  logic [WORD_BITS-1:0] dac_reg;
  logic [WORD_BITS-1:0] dac_next;
  logic clear_hold_reg;
  logic clear_hold_next;
  logic [SEG_COUNT-1:0] seg_reg;
  logic [LADDER_BITS-1:0] ladder_reg;
  logic frame_s1_reg;
  logic frame_s2_reg;
  logic frame_s3_reg;
  logic load_s1_reg;
  logic load_s2_reg;
  logic clear_s1_reg;
  logic clear_s2_reg;
  wire logic frame_rise;
  wire logic word_accept;
  wire logic async_update;
  wire logic sync_update;
  wire logic any_update;
  wire logic [WORD_BITS-1:0] drive_code;
  wire logic [SEG_COUNT-1:0] seg_decoded;

  // frame high or reset parks the link front end
  assign frame_idle = frame_n | ~resetn;

  // full word only after sixteen edges
  assign word_full = (bit_cnt_reg == BITS_PER_WORD);

  // first edge of a frame restarts count
  assign bit_cnt_next = fresh_reg ? CNT_FIRST :
                        (word_full ? BITS_PER_WORD :
                         bit_cnt_reg + CNT_FIRST);

  // DAC register first, then shifted word
  // past sixteen, first received bits of this frame leave
  assign sdo_low_next = fresh_reg ? ~dac_reg[WORD_MSB] :
                        (word_full ? ~shift_reg[WORD_MSB] :
                         ~readback_reg[WORD_MSB]);

  // marks first falling edge of each frame
  always_ff @(negedge serial_clk or posedge frame_idle) begin
    if (frame_idle) begin
      fresh_reg <= 1'b1;
    end else begin
      fresh_reg <= 1'b0;
    end
  end

  always_ff @(negedge serial_clk or negedge resetn) begin
    if (!resetn) begin
      shift_reg <= MIDSCALE_CODE;
    end else if (!frame_n) begin
      shift_reg <= {shift_reg[WORD_MSB-1:0], serial_in};
    end
  end

  // bit counter, held after frame ends
  always_ff @(negedge serial_clk or negedge resetn) begin
    if (!resetn) begin
      bit_cnt_reg <= CNT_RESET;
    end else if (!frame_n) begin
      bit_cnt_reg <= bit_cnt_next;
    end
  end

  // readback copy of the DAC register
  always_ff @(negedge serial_clk or negedge resetn) begin
    if (!resetn) begin
      readback_reg <= MIDSCALE_CODE;
    end else if (!frame_n) begin
      if (fresh_reg) begin
        readback_reg <= {dac_reg[WORD_MSB-1:0], 1'b0};
      end else begin
        readback_reg <= {readback_reg[WORD_MSB-1:0], 1'b0};
      end
    end
  end

  // open-drain pull-down, released outside frames
  always_ff @(negedge serial_clk or posedge frame_idle) begin
    if (frame_idle) begin
      sdo_low_reg <= 1'b0;
    end else begin
      sdo_low_reg <= sdo_low_next;
    end
  end

  assign serial_out_o = 1'b0;
  assign serial_out_oe = sdo_low_reg;

  // two-stage synchronisers, ten clocks per bit
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      {frame_s3_reg, frame_s2_reg, frame_s1_reg} <= SYNC_RESET_HIGH;
    end else begin
      frame_s1_reg <= frame_n;
      frame_s2_reg <= frame_s1_reg;
      frame_s3_reg <= frame_s2_reg;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      load_s1_reg <= 1'b1;
      load_s2_reg <= 1'b1;
    end else begin
      load_s1_reg <= load_strobe_n;
      load_s2_reg <= load_s1_reg;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      clear_s1_reg <= 1'b1;
      clear_s2_reg <= 1'b1;
    end else begin
      clear_s1_reg <= clear_output_n;
      clear_s2_reg <= clear_s1_reg;
    end
  end

  // frame end seen in system domain
  assign frame_rise = frame_s2_reg & ~frame_s3_reg;

  // word moves on at frame end
  assign word_accept = frame_rise & word_full;

  assign async_update = frame_s2_reg & ~load_s2_reg;

  // load low as the full word is accepted at frame end
  assign sync_update = word_accept & ~load_s2_reg;

  assign any_update = async_update | sync_update;

  assign input_next = word_accept ? shift_reg : input_reg;

  assign dac_next = sync_update ? shift_reg :
                    (async_update ? input_reg : dac_reg);

  // clear held until next load, set wins
  assign clear_hold_next = ~clear_s2_reg |
                           (clear_hold_reg & ~any_update);

  assign drive_code = clear_hold_reg ? MIDSCALE_CODE : dac_reg;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      input_reg <= MIDSCALE_CODE;
    end else begin
      input_reg <= input_next;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dac_reg <= MIDSCALE_CODE;
    end else begin
      dac_reg <= dac_next;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      clear_hold_reg <= 1'b0;
    end else begin
      clear_hold_reg <= clear_hold_next;
    end
  end

  segment_decoder u_segment_decoder (
    .code_top(drive_code[WORD_MSB:SEG_LSB]),
    .thermo(seg_decoded)
  );

  // registered switch drive
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      seg_reg <= SEG_RESET;
      ladder_reg <= LADDER_RESET;
    end else begin
      seg_reg <= seg_decoded;
      ladder_reg <= drive_code[LADDER_MSB:0];
    end
  end

  assign segment_switches = seg_reg;
  assign ladder_switches = ladder_reg;
  assign input_code = input_reg;
  assign dac_code = dac_reg;
  assign output_cleared = clear_hold_reg;

endmodule : serial_dac_input_loader

`default_nettype wire
